/* File: rtl/fuse_ctrl_pkg.sv */
// constants, types and helpers shared by the fuse memory controller mode logic
package fuse_ctrl_pkg;

  // ==========================================================================
  // register map
  localparam logic [31:0] MODE_CFG_ADDR = 32'h4000_8000;

  // ==========================================================================
  // field positions of controller_mode_config
  localparam int SRC_MSB    = 29;
  localparam int SRC_LSB    = 28;
  localparam int FAST_BIT   = 8;
  localparam int SINGLE_BIT = 7;
  localparam int DBL_BIT    = 6;
  localparam int PURGE_BIT  = 5;
  localparam int XFER_BIT   = 4;
  localparam int MODE_MSB   = 2;

  // ==========================================================================
  // operating_mode_field codes, 101..111 are test codes
  localparam logic [2:0] MODE_IDLE_STATE = 3'h0;
  localparam logic [2:0] MODE_MANUAL_READ = 3'h1;
  localparam logic [2:0] MODE_MANUAL_PROG = 3'h2;
  localparam logic [2:0] MODE_AUTO_READ = 3'h3;
  localparam logic [2:0] MODE_AUTO_PROG = 3'h4;

  // prog_word_source_select codes
  localparam logic [1:0] SRC_REF_TRIM = 2'h0;
  localparam logic [1:0] SRC_RSSI = 2'h1;
  localparam logic [1:0] SRC_LNA = 2'h2;
  localparam logic [1:0] SRC_OSC_TRIM = 2'h3;

  // ==========================================================================
  // widths and reset values
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] ONE_WORD = 13'h1;
  localparam logic [CNT_W-1:0] NO_WORDS = 13'h0;

  // configuration fields as stored
  typedef struct packed {
    logic [1:0] src_sel;
    logic       fast;
    logic       single;
    logic       dbl;
    logic       purge;
    logic       xfer;
    logic [2:0] mode;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0};

  // analog trim words offered to the alternate programming word
  typedef struct packed {
    logic [15:0] ref_trim;
    logic [15:0] rssi_comp;
    logic [7:0]  radio_pin;
    logic [11:0] lna_a;
    logic [11:0] lna_b;
    logic [4:0]  lna_c;
    logic [3:0]  osc_trim;
  } trim_s;

  // sequencer states of automatic programming
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_PROG  = 2'b10,
    SEQ_DONE  = 2'b11
  } seq_e;

  // ==========================================================================
  // helpers
  function automatic logic is_read(input logic [2:0] m);
    return (m == MODE_MANUAL_READ) || (m == MODE_AUTO_READ);
  endfunction

  function automatic logic is_auto(input logic [2:0] m);
    return (m == MODE_AUTO_READ) || (m == MODE_AUTO_PROG);
  endfunction

  // register image, unused positions read zero
  function automatic logic [31:0] cfg_pack(input cfg_s c);
    logic [31:0] w;
    w = 32'h0;
    w[SRC_MSB:SRC_LSB] = c.src_sel;
    w[FAST_BIT] = c.fast;
    w[SINGLE_BIT] = c.single;
    w[DBL_BIT] = c.dbl;
    w[PURGE_BIT] = c.purge;
    w[XFER_BIT] = c.xfer;
    w[MODE_MSB:0] = c.mode;
    return w;
  endfunction

endpackage

/* File: rtl/prog_word_mux.sv */
// registered selector of the alternate programming word
`timescale 1ns/1ps
module prog_word_mux (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  // selection
  input  wire logic [1:0]           SEL,
  input  wire fuse_ctrl_pkg::trim_s TRIM,
  // result
  output logic [31:0]               WORD
);

  logic [31:0] next_word;

  // ==========================================================================
  // zero padded trim groups
  always_comb begin
    if (SEL == fuse_ctrl_pkg::SRC_REF_TRIM) begin
      next_word = {16'h0, TRIM.ref_trim};
    end else if (SEL == fuse_ctrl_pkg::SRC_RSSI) begin
      next_word = {TRIM.rssi_comp, 8'h0, TRIM.radio_pin};
    end else if (SEL == fuse_ctrl_pkg::SRC_LNA) begin
      next_word = {3'h0, TRIM.lna_c, TRIM.lna_b, TRIM.lna_a};
    end else begin
      next_word = {28'h0, TRIM.osc_trim};
    end
  end

  // registered so the word is stable while the cell is programmed
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      WORD <= 32'h0;
    end else begin
      WORD <= next_word;
    end
  end

endmodule

/* File: rtl/fuse_memory_controller.sv */
// mode and configuration control of the fuse memory controller
`timescale 1ns/1ps
module fuse_memory_controller (
  // clock and reset
  input  wire logic                        CLK,
  input  wire logic                        NRST,
  // register port
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  input  wire logic                        REG_SERIAL,
  input  wire logic [31:0]                 REG_ADDR,
  input  wire logic [31:0]                 REG_WDATA,
  output logic [31:0]                      REG_RDATA,
  // trim words and word count
  input  wire fuse_ctrl_pkg::trim_s        TRIM_WORDS,
  input  wire logic [12:0]                 WORD_COUNT,
  // queue
  input  wire logic                        QUEUE_VALID,
  input  wire logic [31:0]                 QUEUE_DATA,
  output logic                             QUEUE_POP,
  output logic                             QUEUE_PURGE,
  // macrocells
  output logic                             CELL_READ_STB,
  output logic                             CELL_PROG_REQ,
  input  wire logic                        CELL_PROG_DONE,
  output logic [31:0]                      CELL_PROG_WORD,
  output logic                             FAST_TIMING,
  output logic [2:0]                       OP_MODE,
  // transfer engine and status
  output logic                             XFER_ACTIVE,
  output logic [12:0]                      REMAINING_WORDS
);

  fuse_ctrl_pkg::cfg_s cfg;
  fuse_ctrl_pkg::cfg_s next_cfg;
  logic [31:0]         next_rdata;
  logic                wr_hit;
  logic                rd_hit;
  logic [31:0]         alt_word;
  fuse_ctrl_pkg::seq_e state;
  fuse_ctrl_pkg::seq_e next_state;
  logic [12:0]         left;
  logic [12:0]         next_left;
  logic [31:0]         prog_word;
  logic [31:0]         next_prog_word;
  logic                phase;
  logic                next_phase;
  logic                next_xfer;
  logic                auto_prog;
  logic                reading;

  // ==========================================================================
  // register decode
  assign wr_hit = REG_WR && (REG_ADDR == fuse_ctrl_pkg::MODE_CFG_ADDR);
  assign rd_hit = REG_RD && (REG_ADDR == fuse_ctrl_pkg::MODE_CFG_ADDR);

  // field update on write; test codes are stored as written
  always_comb begin
    next_cfg = cfg;
    next_cfg.purge = 1'b0;
    if (wr_hit) begin
      next_cfg.src_sel = REG_WDATA[fuse_ctrl_pkg::SRC_MSB:fuse_ctrl_pkg::SRC_LSB];
      next_cfg.fast = REG_WDATA[fuse_ctrl_pkg::FAST_BIT];
      next_cfg.single = REG_WDATA[fuse_ctrl_pkg::SINGLE_BIT];
      next_cfg.dbl = REG_WDATA[fuse_ctrl_pkg::DBL_BIT];
      next_cfg.purge = REG_WDATA[fuse_ctrl_pkg::PURGE_BIT];
      // the serial path has no bus master behind it, so no transfers
      next_cfg.xfer = REG_WDATA[fuse_ctrl_pkg::XFER_BIT] & ~REG_SERIAL;
      next_cfg.mode = REG_WDATA[fuse_ctrl_pkg::MODE_MSB:0];
    end
  end

  // read answer one cycle after the request, unmapped reads return zero
  always_comb begin
    next_rdata = 32'h0;
    if (rd_hit) begin
      next_rdata = fuse_ctrl_pkg::cfg_pack(cfg);
    end
  end

  // configuration and read data registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cfg <= fuse_ctrl_pkg::CFG_RESET;
      REG_RDATA <= 32'h0;
    end else begin
      cfg <= next_cfg;
      REG_RDATA <= next_rdata;
    end
  end

  // ==========================================================================
  // alternate programming word
  prog_word_mux u_mux (
    .CLK  (CLK),
    .NRST (NRST),
    .SEL  (cfg.src_sel),
    .TRIM (TRIM_WORDS),
    .WORD (alt_word)
  );

  // ==========================================================================
  // automatic programming sequencer
  assign auto_prog = (cfg.mode == fuse_ctrl_pkg::MODE_AUTO_PROG);

  // next state; leaving the mode aborts whatever is in flight
  always_comb begin
    next_state = state;
    next_left = left;
    next_prog_word = prog_word;
    case (state)
      fuse_ctrl_pkg::SEQ_IDLE: begin
        if (auto_prog && cfg.single) begin
          next_prog_word = alt_word;
          next_left = fuse_ctrl_pkg::ONE_WORD;
          next_state = fuse_ctrl_pkg::SEQ_PROG;
        end else if (auto_prog && WORD_COUNT == fuse_ctrl_pkg::NO_WORDS) begin
          next_state = fuse_ctrl_pkg::SEQ_DONE;
        end else if (auto_prog) begin
          next_left = WORD_COUNT;
          next_state = fuse_ctrl_pkg::SEQ_FETCH;
        end
      end
      fuse_ctrl_pkg::SEQ_FETCH: begin
        if (QUEUE_POP) begin
          next_prog_word = QUEUE_DATA;
          next_state = fuse_ctrl_pkg::SEQ_PROG;
        end
      end
      fuse_ctrl_pkg::SEQ_PROG: begin
        if (CELL_PROG_DONE) begin
          next_left = left - fuse_ctrl_pkg::ONE_WORD;
          if (left == fuse_ctrl_pkg::ONE_WORD) begin
            next_state = fuse_ctrl_pkg::SEQ_DONE;
          end else begin
            next_state = fuse_ctrl_pkg::SEQ_FETCH;
          end
        end
      end
      fuse_ctrl_pkg::SEQ_DONE: begin
        next_state = fuse_ctrl_pkg::SEQ_DONE;
      end
      default: begin
        next_state = fuse_ctrl_pkg::SEQ_IDLE;
      end
    endcase
    if (!auto_prog) begin
      next_state = fuse_ctrl_pkg::SEQ_IDLE;
    end
  end

  // sequencer registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state <= fuse_ctrl_pkg::SEQ_IDLE;
      left <= 13'h0;
      prog_word <= 32'h0;
    end else begin
      state <= next_state;
      left <= next_left;
      prog_word <= next_prog_word;
    end
  end

  // no pop in a purge or in the abort cycle after leaving auto program mode
  assign QUEUE_POP = (state == fuse_ctrl_pkg::SEQ_FETCH) && auto_prog && QUEUE_VALID && !cfg.purge;
  assign CELL_PROG_REQ = (state == fuse_ctrl_pkg::SEQ_PROG) && auto_prog;
  assign CELL_PROG_WORD = prog_word;
  assign REMAINING_WORDS = left;
  assign QUEUE_PURGE = cfg.purge;
  assign FAST_TIMING = cfg.fast;
  assign OP_MODE = cfg.mode;

  // ==========================================================================
  // read pacing
  assign reading = fuse_ctrl_pkg::is_read(cfg.mode);

  // phase only toggles in double cycle reads, so single rate strobes every edge
  always_comb begin
    next_phase = 1'b0;
    if (reading && cfg.dbl) begin
      next_phase = ~phase;
    end
  end

  // transfer engine runs only in auto modes and never for the single word
  always_comb begin
    next_xfer = cfg.xfer && fuse_ctrl_pkg::is_auto(cfg.mode);
    if (auto_prog && cfg.single) begin
      next_xfer = 1'b0;
    end
  end

  // pacing and transfer registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      phase <= 1'b0;
      XFER_ACTIVE <= 1'b0;
    end else begin
      phase <= next_phase;
      XFER_ACTIVE <= next_xfer;
    end
  end

  assign CELL_READ_STB = reading && !phase;

  // ==========================================================================
  // assertions
  property p_src_osc;
    @(posedge CLK) disable iff (!NRST)
    (cfg.src_sel == fuse_ctrl_pkg::SRC_OSC_TRIM)
      |=> (alt_word == {28'h0, $past(TRIM_WORDS.osc_trim)});
  endproperty
  a_src_osc: assert property (p_src_osc) else $error("osc trim word wrong");

  property p_src_ref;
    @(posedge CLK) disable iff (!NRST)
    (cfg.src_sel == fuse_ctrl_pkg::SRC_REF_TRIM)
      |=> (alt_word == {16'h0, $past(TRIM_WORDS.ref_trim)});
  endproperty
  a_src_ref: assert property (p_src_ref) else $error("reference trim word wrong");

  property p_fast;
    @(posedge CLK) disable iff (!NRST)
    wr_hit |=> (FAST_TIMING == $past(REG_WDATA[fuse_ctrl_pkg::FAST_BIT]));
  endproperty
  a_fast: assert property (p_fast) else $error("fast timing not taken");

  property p_queue_word;
    @(posedge CLK) disable iff (!NRST)
    (QUEUE_POP && auto_prog && !wr_hit)
      |=> CELL_PROG_REQ && (CELL_PROG_WORD == $past(QUEUE_DATA));
  endproperty
  a_queue_word: assert property (p_queue_word) else $error("queue word not programmed");

  property p_single;
    @(posedge CLK) disable iff (!NRST)
    (state == fuse_ctrl_pkg::SEQ_IDLE && auto_prog && cfg.single && !wr_hit)
      |=> CELL_PROG_REQ && (REMAINING_WORDS == 13'h1) && !QUEUE_POP;
  endproperty
  a_single: assert property (p_single) else $error("single word start wrong");

  property p_dbl_read;
    @(posedge CLK) disable iff (!NRST)
    (CELL_READ_STB && cfg.dbl && !wr_hit) |=> !CELL_READ_STB ##1 (CELL_READ_STB || $past(wr_hit));
  endproperty
  a_dbl_read: assert property (p_dbl_read) else $error("double cycle pacing wrong");

  property p_purge;
    @(posedge CLK) disable iff (!NRST)
    (wr_hit && REG_WDATA[fuse_ctrl_pkg::PURGE_BIT]) |=> QUEUE_PURGE ##1 (!QUEUE_PURGE || $past(wr_hit));
  endproperty
  a_purge: assert property (p_purge) else $error("purge not one cycle");

  property p_no_xfer;
    @(posedge CLK) disable iff (!NRST)
    !cfg.xfer |=> !XFER_ACTIVE;
  endproperty
  a_no_xfer: assert property (p_no_xfer) else $error("transfer without enable");

  property p_xfer_on;
    @(posedge CLK) disable iff (!NRST)
    (cfg.xfer && cfg.mode == fuse_ctrl_pkg::MODE_AUTO_READ) |=> XFER_ACTIVE;
  endproperty
  a_xfer_on: assert property (p_xfer_on) else $error("transfer engine not started");

  property p_serial;
    @(posedge CLK) disable iff (!NRST)
    (wr_hit && REG_SERIAL) |=> !cfg.xfer ##1 !XFER_ACTIVE;
  endproperty
  a_serial: assert property (p_serial) else $error("serial write kept transfer enable");

  property p_single_idle;
    @(posedge CLK) disable iff (!NRST)
    (auto_prog && cfg.single) |=> !XFER_ACTIVE;
  endproperty
  a_single_idle: assert property (p_single_idle) else $error("transfer engine busy on single");

  property p_idle_quiet;
    @(posedge CLK) disable iff (!NRST)
    (OP_MODE == fuse_ctrl_pkg::MODE_IDLE_STATE) |-> !CELL_READ_STB && !CELL_PROG_REQ && !QUEUE_POP;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity in idle mode");

  property p_reserved;
    @(posedge CLK) disable iff (!NRST)
    (REG_RDATA[31:30] == 2'h0) && (REG_RDATA[27:9] == 19'h0) && !REG_RDATA[3];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  // main scenarios
  c_single: cover property (@(posedge CLK) disable iff (!NRST)
    (CELL_PROG_REQ && cfg.single) ##1 (state == fuse_ctrl_pkg::SEQ_DONE));
  c_queue: cover property (@(posedge CLK) disable iff (!NRST)
    QUEUE_POP ##[1:20] (CELL_PROG_DONE && REMAINING_WORDS == 13'h2));
  c_dbl: cover property (@(posedge CLK) disable iff (!NRST)
    (CELL_READ_STB && cfg.dbl) ##2 CELL_READ_STB);
  c_purge: cover property (@(posedge CLK) disable iff (!NRST) QUEUE_PURGE);

endmodule

/* File: tb/fuse_cell_model.sv */
// queue and macrocell stand-in facing the fuse memory controller
`timescale 1ns/1ps
module fuse_cell_model (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // bench control
  input  wire logic        FILL,
  input  wire logic [3:0]  DELAY,
  // queue side
  input  wire logic        QUEUE_POP,
  input  wire logic        QUEUE_PURGE,
  output logic             QUEUE_VALID,
  output logic [31:0]      QUEUE_DATA,
  // macrocell side
  input  wire logic        CELL_PROG_REQ,
  output logic             CELL_PROG_DONE
);
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [3:0] cnt;

  // ==========================================================================
  // queue: numbered words expose order slips; empty queue never shows a word
  assign QUEUE_VALID = (wr_idx != rd_idx);
  assign QUEUE_DATA  = QUEUE_VALID ? {28'h51c0000, rd_idx} : ~{28'h51c0000, rd_idx};

  // purge empties the store at once, words leave in fill order
  always_ff @(posedge CLK) begin
    if (!NRST || QUEUE_PURGE) begin
      wr_idx <= 4'h0;
      rd_idx <= 4'h0;
    end else begin
      wr_idx <= wr_idx + {3'h0, FILL};
      rd_idx <= rd_idx + {3'h0, QUEUE_POP & QUEUE_VALID};
    end
  end

  // ==========================================================================
  // macrocell ends a word DELAY+1 cycles after the request rises, one-cycle pulse
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cnt            <= 4'h0;
      CELL_PROG_DONE <= 1'b0;
    end else begin
      CELL_PROG_DONE <= CELL_PROG_REQ && !CELL_PROG_DONE && (cnt == DELAY);
      cnt            <= (CELL_PROG_DONE || !CELL_PROG_REQ) ? 4'h0 : cnt + 4'h1;
    end
  end
endmodule

/* File: tb/tb_fuse_memory_controller.sv */
// self-checking bench of the fuse memory controller mode logic
`timescale 1ns/1ps
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL %s expected %h seen %h", what, exp, got); end end
module tb_fuse_memory_controller;
  // ==========================================================================
  // signals
  localparam logic [31:0] CFG_ADDR = fuse_ctrl_pkg::MODE_CFG_ADDR;
  logic                 CLK, NRST, REG_WR, REG_RD, REG_SERIAL, FILL;
  logic [31:0]          REG_ADDR, REG_WDATA, REG_RDATA, QUEUE_DATA, CELL_PROG_WORD, rd;
  fuse_ctrl_pkg::trim_s TRIM_WORDS;
  logic [12:0]          WORD_COUNT, REMAINING_WORDS;
  logic                 QUEUE_VALID, QUEUE_POP, QUEUE_PURGE, CELL_READ_STB, CELL_PROG_REQ;
  logic                 CELL_PROG_DONE, FAST_TIMING, XFER_ACTIVE, s1, s2;
  logic [2:0]           OP_MODE;
  logic [3:0]           DELAY;
  logic [31:0]          alt [4] = '{32'h0000_1234, 32'habcd_005a, 32'h1565_4321, 32'h0000_0009};
  int                   fail_count, num_checks, pops;

  // ==========================================================================
  // design and far side
  fuse_memory_controller u_dut (.CLK, .NRST, .REG_WR, .REG_RD, .REG_SERIAL, .REG_ADDR, .REG_WDATA,
    .REG_RDATA, .TRIM_WORDS, .WORD_COUNT, .QUEUE_VALID, .QUEUE_DATA, .QUEUE_POP, .QUEUE_PURGE,
    .CELL_READ_STB, .CELL_PROG_REQ, .CELL_PROG_DONE, .CELL_PROG_WORD, .FAST_TIMING, .OP_MODE,
    .XFER_ACTIVE, .REMAINING_WORDS);
  fuse_cell_model u_cells (.CLK, .NRST, .FILL, .DELAY, .QUEUE_POP, .QUEUE_PURGE, .QUEUE_VALID,
    .QUEUE_DATA, .CELL_PROG_REQ, .CELL_PROG_DONE);

  // ==========================================================================
  // access tasks, every drive lands 1 ns after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic ser);
    tick(1);
    REG_WR     = 1'b1;
    REG_ADDR   = a;
    REG_WDATA  = d;
    REG_SERIAL = ser;
    tick(1);
    REG_WR     = 1'b0;
    REG_SERIAL = 1'b0;
  endtask

  task automatic rdreg(input logic [31:0] a, output logic [31:0] d);
    tick(1);
    REG_RD   = 1'b1;
    REG_ADDR = a;
    tick(1);
    REG_RD = 1'b0;
    d      = REG_RDATA;
  endtask

  // always pass through idle before an active mode
  task automatic go(input logic [31:0] d);
    wr(CFG_ADDR, 32'h0, 1'b0);
    wr(CFG_ADDR, d, 1'b0);
  endtask

  // waits, bounded, for one programmed word and its completion
  task automatic prog_word(input logic [31:0] exp);
    for (int i = 0; i < 40 && CELL_PROG_REQ !== 1'b1; i++) tick(1);
    `CHK("prog request", 1'b1, CELL_PROG_REQ)
    `CHK("prog word", exp, CELL_PROG_WORD)
    for (int i = 0; i < 40 && CELL_PROG_REQ !== 1'b0; i++) tick(1);
  endtask

  task automatic done_test(input string s);
    $display("test %s finished, mismatches so far %0d", s, fail_count);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock, pop counter and watchdog
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  always @(posedge CLK) if (QUEUE_POP === 1'b1) pops++;

  // a few hundred cycles suffice, so 100 us means a hang
  initial begin
    #100us;
    fail_count++;
    summarize();
  end

  // ==========================================================================
  // tests
  initial begin
    NRST = 1'b0; REG_WR = 1'b0; REG_RD = 1'b0; REG_SERIAL = 1'b0; FILL = 1'b0;
    REG_ADDR = 32'h0; REG_WDATA = 32'h0; WORD_COUNT = 13'h0; DELAY = 4'h1;
    TRIM_WORDS = '{16'h1234, 16'habcd, 8'h5a, 12'h321, 12'h654, 5'h15, 4'h9};
    fail_count = 0; num_checks = 0; pops = 0;
    repeat (12) @(posedge CLK);
    #1 NRST = 1'b1;
    `CHK("reset mode", 3'h0, OP_MODE)
    rdreg(CFG_ADDR, rd);
    `CHK("reset image", 32'h0, rd)
    done_test("reset");
    // all writable bits except purge set in idle; reserved and bit 3 must stay zero
    wr(CFG_ADDR, 32'hffff_ffd8, 1'b0);
    rdreg(CFG_ADDR, rd);
    `CHK("field image", 32'h3000_01d0, rd)
    wr(CFG_ADDR + 32'h4, 32'h0, 1'b0);
    rdreg(CFG_ADDR, rd);
    `CHK("unmapped write", 32'h3000_01d0, rd)
    rdreg(CFG_ADDR + 32'h4, rd);
    `CHK("unmapped read", 32'h0, rd)
    wr(CFG_ADDR, 32'h0, 1'b0);
    wr(CFG_ADDR, 32'h13, 1'b1);
    tick(1);
    rdreg(CFG_ADDR, rd);
    `CHK("serial image", 32'h3, rd)
    `CHK("serial engine", 1'b0, XFER_ACTIVE)
    done_test("register");
    // every active mode 001..100 with both read paces; test codes are never written
    for (int m = 1; m <= 4; m++) begin
      for (int d = 0; d < 2; d++) begin
        go({23'h0, ~d[0], 1'b0, d[0], 2'b01, 1'b0, m[2:0]});
        tick(1);
        s1 = CELL_READ_STB;
        tick(1);
        s2 = CELL_READ_STB;
        `CHK("mode", m[2:0], OP_MODE)
        `CHK("fast timing", ~d[0], FAST_TIMING)
        `CHK("engine", m >= 3, XFER_ACTIVE)
        `CHK("read pace", (m == 1 || m == 3) ? (d ? 2'h1 : 2'h2) : 2'h0, {1'b0, s1} + {1'b0, s2})
      end
    end
    done_test("modes");
    wr(CFG_ADDR, 32'h0, 1'b0);
    FILL = 1'b1;
    tick(2);
    FILL = 1'b0;
    `CHK("queue filled", 1'b1, QUEUE_VALID)
    wr(CFG_ADDR, 32'h20, 1'b0);
    `CHK("purge pulse", 1'b1, QUEUE_PURGE)
    tick(1);
    `CHK("purge ends", 1'b0, QUEUE_PURGE)
    `CHK("queue emptied", 1'b0, QUEUE_VALID)
    rdreg(CFG_ADDR, rd);
    `CHK("purge clears", 32'h0, rd)
    done_test("purge");
    // three queued words with a slow macrocell
    FILL = 1'b1;
    tick(3);
    FILL = 1'b0;
    WORD_COUNT = 13'h3;
    DELAY = 4'h6;
    pops = 0;
    go(32'h4);
    for (int i = 0; i < 3; i++) prog_word(32'h51c0_0000 + i);
    tick(2);
    `CHK("words left", 13'h0, REMAINING_WORDS)
    `CHK("request idle", 1'b0, CELL_PROG_REQ)
    `CHK("queue pops", 3, pops)
    done_test("queue program");
    // one word per source; queue, count and transfer enable ignored
    FILL = 1'b1;
    tick(1);
    FILL = 1'b0;
    DELAY = 4'h0;
    for (int s = 0; s < 4; s++) begin
      wr(CFG_ADDR, 32'h0, 1'b0);
      wr(CFG_ADDR, {2'b0, s[1:0], 28'h0}, 1'b0);
      wr(CFG_ADDR, {2'b0, s[1:0], 20'h0, 8'h94}, 1'b0);
      tick(1);
      `CHK("single engine", 1'b0, XFER_ACTIVE)
      prog_word(alt[s]);
      tick(3);
      `CHK("one word only", 1'b0, CELL_PROG_REQ)
    end
    `CHK("single pops", 3, pops)
    done_test("single word");
    // leaving mode 100 as a word completes aborts; idle mode takes no queued word
    FILL = 1'b1;
    tick(1);
    FILL = 1'b0;
    go(32'h4);
    for (int i = 0; i < 40 && CELL_PROG_REQ !== 1'b1; i++) tick(1);
    `CHK("abort word", 32'h51c0_0003, CELL_PROG_WORD)
    wr(CFG_ADDR, 32'h0, 1'b0);
    tick(3);
    `CHK("abort request", 1'b0, CELL_PROG_REQ)
    `CHK("abort pops", 4, pops)
    `CHK("abort mode", 3'h0, OP_MODE)
    done_test("abort");
    summarize();
  end
endmodule
